// ---- verilog/scs_pkg.sv ----
// Constants, state codes and timing counts for the SMBus configuration slave.
// Assumes a 100 MHz system clock; link-side logic runs on its own sampling clock.
package scs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_SYS_MHZ = 100;
  localparam int DETECT_TIME_US = 1000;
  localparam int DETECT_CYCLES = DETECT_TIME_US * CLK_SYS_MHZ;
  localparam int TIMEOUT_MIN_MS = 25;
  localparam int TIMEOUT_MAX_MS = 35;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MIN_MS * 1000 * CLK_SYS_MHZ;
  localparam int CNT_W = 22;
  localparam logic [CNT_W-1:0] STRAP_SAMPLE = 22'h00_0004;

  // ----------------------------------------------------------------
  // Addresses and register map
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR_LO = 7'h2C;
  localparam logic [6:0] SLAVE_ADDR_HI = 7'h2D;
  localparam int REG_NUM = 16;
  localparam logic [4:0] SCOPE_LEGACY = 5'h08;
  localparam logic [4:0] SCOPE_ADVANCED = 5'h10;
  localparam logic [3:0] DONE_IDX = 4'h7;
  localparam int DONE_BIT = 0;

  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SYS_DETECT = 3'b001,
    SYS_HOSTCFG = 3'b010,
    SYS_INIT = 3'b100
  } scs_sys_e;

  typedef enum logic [8:0] {
    LNK_IDLE = 9'b0_0000_0001,
    LNK_RX = 9'b0_0000_0010,
    LNK_ACKW = 9'b0_0000_0100,
    LNK_ACK = 9'b0_0000_1000,
    LNK_STRETCH = 9'b0_0001_0000,
    LNK_TX = 9'b0_0010_0000,
    LNK_TXACK = 9'b0_0100_0000,
    LNK_TXNEXT = 9'b0_1000_0000,
    LNK_IGNORE = 9'b1_0000_0000
  } scs_link_e;

endpackage

// ---- verilog/scs_sync2.sv ----
// Two-flop synchroniser for a group of independent level or toggle bits.
// Assumes each bit is a level or a toggle; multi-bit words never pass here.
`timescale 1ns/1ns
`default_nettype none
module scs_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule
`default_nettype wire

// ---- verilog/scs_config_slave.sv ----
// SMBus configuration slave: pull-up sensing, init gating, block access.
// Assumes open-drain pins resolved outside; clk_link oversamples the bus.
`timescale 1ns/1ns
`default_nettype none
module scs_config_slave #(
  parameter int DETECT_CYC = scs_pkg::DETECT_CYCLES,
  parameter int TIMEOUT_CYC = scs_pkg::TIMEOUT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_link,
  input wire logic configBusDataPinIn,
  output logic configBusDataPinOut,
  output logic configBusDataPinOeN,
  input wire logic configBusClockPinIn,
  output logic configBusClockPinOut,
  output logic configBusClockPinOeN,
  input wire logic legacySelIn,
  input wire logic addrSelIn,
  input wire logic [127:0] otpValue,
  output logic [127:0] cfgValue,
  output logic slaveEnabled,
  output logic legacyMode,
  output logic waitingHost,
  output logic initProceed,
  output logic otpOnly,
  output logic dataPullupEn
);
  import scs_pkg::*;

  // ----------------------------------------------------------------
  // State records
  // ----------------------------------------------------------------
  typedef struct packed {
    scs_sys_e st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] lowCnt;
    logic pullOk;
    logic strapVal;
    logic legacy;
    logic slaveEn;
    logic pullupEn;
    logic initGo;
    logic otpOnly;
    logic abort;
    logic wrAckT;
    logic rdAckT;
    logic [15:0] written;
    logic [REG_NUM-1:0][7:0] regs;
    logic [REG_NUM-1:0][7:0] cfg;
    logic [REG_NUM-1:0][7:0] snap;
    logic [4:0] snapScope;
  } scs_sys_s;

  typedef struct packed {
    scs_link_e st;
    logic sclP;
    logic sdaP;
    logic [7:0] shift;
    logic [2:0] bitCnt;
    logic [1:0] phase;
    logic justStarted;
    logic readMode;
    logic haveCmd;
    logic haveCount;
    logic [7:0] cmd;
    logic [7:0] count;
    logic [4:0] wrN;
    logic [4:0] rdIdx;
    logic [REG_NUM-1:0][7:0] wbuf;
    logic wrReqT;
    logic rdReqT;
    logic sdaOeN;
    logic sclOeN;
  } scs_lnk_s;

  scs_sys_s s_q, s_d;
  scs_lnk_s l_q, l_d;
  logic [4:0] sysSyncQ;
  logic [6:0] lnkSyncQ;
  logic sclS, sdaS, strapS, wrReqS, rdReqS;
  logic sclL, sdaL, addrSelL, enL, abortL, wrAckL, rdAckL;
  logic rise, fall, startDet, stopDet, wrPend, rdPend;
  logic [6:0] myAddr;
  logic [7:0] newByte;
  logic [7:0] txByte;
  logic [7:0] rdPos;

  // ----------------------------------------------------------------
  // Clock crossings
  // ----------------------------------------------------------------
  scs_sync2 #(.W(5)) u_sync_sys (
    .clk(clk_sys),
    .resetn(resetn),
    .d({configBusClockPinIn, configBusDataPinIn, legacySelIn, l_q.wrReqT, l_q.rdReqT}),
    .q(sysSyncQ)
  );

  scs_sync2 #(.W(7)) u_sync_lnk (
    .clk(clk_link),
    .resetn(resetn),
    .d({configBusClockPinIn, configBusDataPinIn, addrSelIn, s_q.slaveEn, s_q.abort,
        s_q.wrAckT, s_q.rdAckT}),
    .q(lnkSyncQ)
  );

  assign {sclS, sdaS, strapS, wrReqS, rdReqS} = sysSyncQ;
  assign {sclL, sdaL, addrSelL, enL, abortL, wrAckL, rdAckL} = lnkSyncQ;

  // ----------------------------------------------------------------
  // System side: detection, init gating, register bank, timeout
  // ----------------------------------------------------------------
  // Sync outputs read low for two cycles after reset, so sensing waits
  always_comb begin
    logic [7:0] idx;
    idx = 8'h00;
    s_d = s_q;
    case (s_q.st)
      SYS_DETECT: begin
        s_d.cnt = s_q.cnt + 22'h00_0001;
        if (s_q.cnt >= STRAP_SAMPLE && (!sclS || !sdaS)) begin
          s_d.pullOk = 1'b0;
        end
        if (s_q.cnt == STRAP_SAMPLE) begin
          s_d.strapVal = strapS;
          s_d.pullupEn = 1'b1;
        end
        if (s_q.cnt == CNT_W'(DETECT_CYC - 1)) begin
          s_d.slaveEn = s_q.pullOk & sclS & sdaS;
          s_d.legacy = s_q.strapVal & s_q.pullOk & sclS & sdaS;
          s_d.otpOnly = !(s_q.pullOk & sclS & sdaS);
          s_d.initGo = !(s_q.pullOk & sclS & sdaS);
          s_d.st = (s_q.pullOk & sclS & sdaS) ? SYS_HOSTCFG : SYS_INIT;
        end
      end
      SYS_HOSTCFG: s_d.st = SYS_HOSTCFG; // Held until the done bit lands
      SYS_INIT: s_d.initGo = 1'b1;
      default: s_d.st = SYS_DETECT;
    endcase
    // Committed block write; link holds buffer stable until acknowledged
    if (wrReqS != s_q.wrAckT) begin
      s_d.wrAckT = wrReqS;
      for (int i = 0; i < REG_NUM; i++) begin
        idx = l_q.cmd + 8'(i);
        if (8'(i) < l_q.count && idx < {3'b000, (s_q.legacy ? SCOPE_LEGACY : SCOPE_ADVANCED)}) begin
          s_d.regs[idx[3:0]] = l_q.wbuf[i];
          s_d.written[idx[3:0]] = 1'b1;
          if (idx[3:0] == DONE_IDX && l_q.wbuf[i][DONE_BIT] && s_q.st == SYS_HOSTCFG) begin
            s_d.st = SYS_INIT;
            s_d.initGo = 1'b1;
          end
        end
      end
    end
    // Host value wins over the one-time value, byte by byte
    for (int j = 0; j < REG_NUM; j++) begin
      s_d.cfg[j] = s_q.written[j] ? s_q.regs[j] : otpValue[j*8 +: 8];
    end
    // Read snapshot; stays frozen while the link reads it
    if (rdReqS != s_q.rdAckT) begin
      s_d.rdAckT = rdReqS;
      s_d.snap = s_q.cfg;
      s_d.snapScope = s_q.legacy ? SCOPE_LEGACY : SCOPE_ADVANCED;
    end
    // Clock-low watchdog; reset of the link well before the upper bound
    if (sclS || !s_q.slaveEn) begin
      s_d.lowCnt = '0;
      s_d.abort = 1'b0;
    end else if (s_q.lowCnt >= CNT_W'(TIMEOUT_CYC - 1)) begin
      s_d.abort = 1'b1;
    end else begin
      s_d.lowCnt = s_q.lowCnt + 22'h00_0001;
    end
  end

  // Asynchronous reset clears all transfers and register contents
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.st <= SYS_DETECT;
      s_q.pullOk <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Link side: bit and byte engine
  // ----------------------------------------------------------------
  assign rise = sclL & !l_q.sclP;
  assign fall = !sclL & l_q.sclP;
  assign startDet = sclL & l_q.sclP & l_q.sdaP & !sdaL;
  assign stopDet = sclL & l_q.sclP & !l_q.sdaP & sdaL;
  assign wrPend = l_q.wrReqT != wrAckL;
  assign rdPend = l_q.rdReqT != rdAckL;
  assign myAddr = addrSelL ? SLAVE_ADDR_HI : SLAVE_ADDR_LO;
  assign newByte = {l_q.shift[6:0], sdaL};
  assign rdPos = l_q.cmd + {3'b000, l_q.rdIdx} - 8'h01;

  // Byte to send: count first, then data; beyond scope reads zero
  always_comb begin
    txByte = 8'h00;
    if (l_q.rdIdx == 5'h00) begin
      if (l_q.cmd < {3'b000, s_q.snapScope}) begin
        txByte = {3'b000, s_q.snapScope} - l_q.cmd;
      end
    end else if (rdPos < {3'b000, s_q.snapScope}) begin
      txByte = s_q.snap[rdPos[3:0]];
    end
  end

  always_comb begin
    l_d = l_q;
    l_d.sclP = sclL;
    l_d.sdaP = sdaL;
    if (abortL || !enL) begin
      l_d.st = LNK_IDLE;
      l_d.sdaOeN = 1'b1;
      l_d.sclOeN = 1'b1;
      l_d.haveCmd = 1'b0;
      l_d.haveCount = 1'b0;
    end else if (startDet) begin
      l_d.st = LNK_RX;
      l_d.bitCnt = 3'h0;
      l_d.phase = 2'h0;
      l_d.justStarted = 1'b1;
      l_d.sdaOeN = 1'b1;
      l_d.sclOeN = 1'b1;
    end else if (stopDet) begin
      // Commit only a complete block write; anything else is dropped
      if (!l_q.justStarted && !l_q.readMode && l_q.haveCount && l_q.count != 8'h00 &&
          l_q.count == {3'b000, l_q.wrN} && !wrPend) begin
        l_d.wrReqT = !l_q.wrReqT;
      end
      l_d.st = LNK_IDLE;
      l_d.haveCmd = 1'b0;
      l_d.haveCount = 1'b0;
      l_d.readMode = 1'b0;
      l_d.sdaOeN = 1'b1;
      l_d.sclOeN = 1'b1;
    end else begin
      case (l_q.st)
        LNK_RX: if (rise) begin
          l_d.justStarted = 1'b0;
          l_d.shift = newByte;
          l_d.bitCnt = l_q.bitCnt + 3'h1;
          if (l_q.bitCnt == 3'h7) begin
            l_d.st = LNK_ACKW;
            case (l_q.phase)
              2'h0: begin
                // Only our own address; alert response address never matches
                if (newByte[7:1] != myAddr || wrPend) begin
                  l_d.st = LNK_IGNORE;
                end else if (newByte[0]) begin
                  if (l_q.haveCmd) begin
                    l_d.readMode = 1'b1;
                    l_d.rdIdx = 5'h00;
                    l_d.rdReqT = !l_q.rdReqT;
                  end else begin
                    l_d.st = LNK_IGNORE;
                  end
                end else begin
                  l_d.phase = 2'h1;
                  l_d.readMode = 1'b0;
                  l_d.haveCmd = 1'b0;
                  l_d.haveCount = 1'b0;
                  l_d.wrN = 5'h00;
                end
              end
              2'h1: begin
                l_d.cmd = newByte;
                l_d.haveCmd = 1'b1;
                l_d.phase = 2'h2;
              end
              2'h2: begin
                l_d.count = newByte;
                l_d.haveCount = 1'b1;
                l_d.phase = 2'h3;
              end
              default: begin
                if (l_q.wrN < 5'h10) begin
                  l_d.wbuf[l_q.wrN[3:0]] = newByte;
                  l_d.wrN = l_q.wrN + 5'h01;
                end else begin
                  l_d.st = LNK_IGNORE; // Buffer full: refuse with NACK
                end
              end
            endcase
          end
        end
        LNK_ACKW: if (fall) begin
          l_d.sdaOeN = 1'b0;
          l_d.st = LNK_ACK;
        end
        LNK_ACK: if (fall) begin
          l_d.sdaOeN = 1'b1;
          l_d.bitCnt = 3'h0;
          if (!l_q.readMode) begin
            l_d.st = LNK_RX;
          end else if (rdPend) begin
            l_d.sclOeN = 1'b0; // Hold clock until snapshot arrives
            l_d.st = LNK_STRETCH;
          end else begin
            l_d.shift = txByte;
            l_d.sdaOeN = txByte[7];
            l_d.rdIdx = l_q.rdIdx + 5'h01;
            l_d.st = LNK_TX;
          end
        end
        LNK_STRETCH: if (!rdPend) begin
          l_d.shift = txByte;
          l_d.sdaOeN = txByte[7];
          l_d.rdIdx = l_q.rdIdx + 5'h01;
          l_d.sclOeN = 1'b1;
          l_d.st = LNK_TX;
        end
        LNK_TX: if (fall) begin
          if (l_q.bitCnt == 3'h7) begin
            l_d.sdaOeN = 1'b1;
            l_d.st = LNK_TXACK;
          end else begin
            l_d.shift = {l_q.shift[6:0], 1'b0};
            l_d.sdaOeN = l_q.shift[6];
            l_d.bitCnt = l_q.bitCnt + 3'h1;
          end
        end
        LNK_TXACK: if (rise) begin
          l_d.st = sdaL ? LNK_IGNORE : LNK_TXNEXT;
        end
        LNK_TXNEXT: if (fall) begin
          l_d.shift = txByte;
          l_d.sdaOeN = txByte[7];
          l_d.bitCnt = 3'h0;
          l_d.rdIdx = (l_q.rdIdx == 5'h1F) ? l_q.rdIdx : l_q.rdIdx + 5'h01;
          l_d.st = LNK_TX;
        end
        LNK_IDLE, LNK_IGNORE: l_d.sdaOeN = 1'b1;
        default: l_d.st = LNK_IDLE;
      endcase
    end
  end

  // Link state on the bus sampling clock
  always_ff @(posedge clk_link or negedge resetn) begin
    if (!resetn) begin
      l_q <= '0;
      l_q.st <= LNK_IDLE;
      l_q.sdaOeN <= 1'b1;
      l_q.sclOeN <= 1'b1;
    end else begin
      l_q <= l_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open-drain pins only ever pull low
  assign configBusDataPinOut = 1'b0;
  assign configBusClockPinOut = 1'b0;
  assign configBusDataPinOeN = l_q.sdaOeN;
  assign configBusClockPinOeN = l_q.sclOeN;
  assign cfgValue = s_q.cfg;
  assign slaveEnabled = s_q.slaveEn;
  assign legacyMode = s_q.legacy;
  assign waitingHost = s_q.st[1]; // One-hot bit of the host wait state, straight from its flop
  assign initProceed = s_q.initGo;
  assign otpOnly = s_q.otpOnly;
  assign dataPullupEn = s_q.pullupEn;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_low_clears_pull;
    @(posedge clk_sys) disable iff (!resetn)
    (s_q.st == SYS_DETECT && s_q.cnt >= STRAP_SAMPLE && !sclS) |=> !s_q.pullOk;
  endproperty
  a_low_clears_pull: assert property (p_low_clears_pull)
    else $error("low clock during sensing left pull-up flag set");

  property p_disabled_goes_init;
    @(posedge clk_sys) disable iff (!resetn)
    (s_q.st == SYS_DETECT && s_q.cnt == CNT_W'(DETECT_CYC - 1) && !s_q.pullOk)
      |=> (s_q.st == SYS_INIT && s_q.initGo && s_q.otpOnly && !s_q.slaveEn);
  endproperty
  a_disabled_goes_init: assert property (p_disabled_goes_init)
    else $error("disabled slave did not go straight to init");

  property p_wait_host;
    @(posedge clk_sys) disable iff (!resetn)
    (s_q.st == SYS_HOSTCFG && wrReqS == s_q.wrAckT) |=> (s_q.st == SYS_HOSTCFG && !s_q.initGo);
  endproperty
  a_wait_host: assert property (p_wait_host)
    else $error("left host wait without a write");

  property p_legacy_needs_enable;
    @(posedge clk_sys) disable iff (!resetn)
    s_q.legacy |-> (s_q.slaveEn && s_q.strapVal);
  endproperty
  a_legacy_needs_enable: assert property (p_legacy_needs_enable)
    else $error("legacy mode without enabled slave and strap");

  property p_pullup_after_strap;
    @(posedge clk_sys) disable iff (!resetn)
    (s_q.st == SYS_DETECT && s_q.cnt < STRAP_SAMPLE) |=> !s_q.pullupEn;
  endproperty
  a_pullup_after_strap: assert property (p_pullup_after_strap)
    else $error("data pull-up on before strap sampling");

  property p_timeout_abort;
    @(posedge clk_sys) disable iff (!resetn)
    (s_q.slaveEn && !sclS && s_q.lowCnt == CNT_W'(TIMEOUT_CYC - 1)) |=> s_q.abort;
  endproperty
  a_timeout_abort: assert property (p_timeout_abort)
    else $error("clock-low timeout did not abort");

  property p_bus_reset;
    @(posedge clk_link) disable iff (!resetn)
    (stopDet && l_q.justStarted && !abortL && enL)
      |=> (l_q.st == LNK_IDLE && l_q.wrReqT == $past(l_q.wrReqT) && l_q.sdaOeN);
  endproperty
  a_bus_reset: assert property (p_bus_reset)
    else $error("start then stop did not reset to idle");

  property p_wrong_addr_nack;
    @(posedge clk_link) disable iff (!resetn)
    (l_q.st == LNK_RX && l_q.phase == 2'h0 && rise && l_q.bitCnt == 3'h7 &&
     newByte[7:1] != myAddr && !startDet && !stopDet && !abortL && enL)
      |=> (l_q.st == LNK_IGNORE) [*2];
  endproperty
  a_wrong_addr_nack: assert property (p_wrong_addr_nack)
    else $error("foreign address was not ignored");

  property p_stretch_cause;
    @(posedge clk_link) disable iff (!resetn)
    $fell(l_q.sclOeN) |-> ($past(rdPend) && l_q.st == LNK_STRETCH);
  endproperty
  a_stretch_cause: assert property (p_stretch_cause)
    else $error("clock held low without a pending read");

  property p_short_block_dropped;
    @(posedge clk_link) disable iff (!resetn)
    (stopDet && l_q.count != {3'b000, l_q.wrN}) |=> l_q.wrReqT == $past(l_q.wrReqT);
  endproperty
  a_short_block_dropped: assert property (p_short_block_dropped)
    else $error("incomplete block write was committed");

endmodule
`default_nettype wire

// ---- verif/scs_host_model.sv ----
// SMBus host model that configures the slave over the two-wire link.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ns
`default_nettype none
module scs_host_model (
  output logic sdaOeN,
  output logic sclOeN,
  input wire logic sdaIn,
  input wire logic sclIn
);
  localparam int HALF = 400;
  initial begin
    sdaOeN = 1'b1;
    sclOeN = 1'b1;
  end
  // Release clock and wait out any stretch; bounded so a stuck line cannot hang
  task automatic sclRise();
    sclOeN = 1'b1;
    for (int i = 0; i < 4000 && sclIn !== 1'b1; i++) #10;
  endtask
  // One clock pulse; data is sampled mid-high and changes only while clock is low
  task automatic pulse(output logic b);
    #HALF;
    sclRise();
    #(HALF / 2);
    b = sdaIn;
    #(HALF / 2);
    sclOeN = 1'b0;
  endtask
  // START from idle, or repeated START from clock low
  task automatic start();
    sdaOeN = 1'b1;
    #HALF;
    sclRise();
    #HALF;
    sdaOeN = 1'b0;
    #HALF;
    sclOeN = 1'b0;
  endtask
  // STOP, also used to close a transfer broken by a clock-low timeout
  task automatic stop();
    sdaOeN = 1'b0;
    #HALF;
    sclRise();
    #HALF;
    sdaOeN = 1'b1;
    #HALF;
  endtask
  // START then STOP with no clock edge between them
  task automatic busReset();
    sdaOeN = 1'b1;
    #HALF;
    sclRise();
    #HALF;
    sdaOeN = 1'b0;
    #HALF;
    sdaOeN = 1'b1;
    #HALF;
  endtask
  task automatic writeByte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      sdaOeN = d[i];
      pulse(b);
    end
    sdaOeN = 1'b1;
    pulse(b);
    ack = ~b;
  endtask
  task automatic readByte(input logic ackIt, output logic [7:0] d);
    logic b;
    sdaOeN = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      pulse(b);
      d[i] = b;
    end
    sdaOeN = ~ackIt;
    pulse(b);
    sdaOeN = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- verif/scs_config_slave_bench.sv ----
// Self-checking bench for the configuration slave with a host model on the link.
// Assumes shortened detect and timeout counts; lines resolved here with pull-ups.
`timescale 1ns/1ns
`default_nettype none
module scs_config_slave_bench;
  import scs_pkg::*;
  localparam logic [127:0] OTP = 128'h1111_2222_3333_4444_5454_6666_7777_8888;
  logic clkSys = 1'b0, clkLink = 1'b0, resetn = 1'b0, legacySelIn = 1'b0, addrSelIn = 1'b0;
  logic pullSda = 1'b1, pullScl = 1'b1;
  logic dOeN, cOeN, hSda, hScl, slaveEnabled, legacyMode, waitingHost, initProceed;
  logic otpOnly, dataPullupEn;
  logic [127:0] cfgValue;
  wire logic sda = pullSda & dOeN & hSda;
  wire logic scl = pullScl & cOeN & hScl;
  int miscompares = 0, nCompared = 0;
  initial forever #5 clkSys = ~clkSys;
  initial begin
    #7;
    forever #32 clkLink = ~clkLink;
  end
  scs_config_slave #(.DETECT_CYC(40), .TIMEOUT_CYC(200)) u_dut (
    .clk_sys(clkSys), .resetn(resetn), .clk_link(clkLink),
    .configBusDataPinIn(sda), .configBusDataPinOut(), .configBusDataPinOeN(dOeN),
    .configBusClockPinIn(scl), .configBusClockPinOut(), .configBusClockPinOeN(cOeN),
    .legacySelIn(legacySelIn), .addrSelIn(addrSelIn), .otpValue(OTP), .cfgValue(cfgValue),
    .slaveEnabled(slaveEnabled), .legacyMode(legacyMode), .waitingHost(waitingHost),
    .initProceed(initProceed), .otpOnly(otpOnly), .dataPullupEn(dataPullupEn));
  scs_host_model host (.sdaOeN(hSda), .sclOeN(hScl), .sdaIn(sda), .sclIn(scl));
  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d miscompares %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Reset with chosen straps; a glitch drops data pull-up inside the detect window
  task automatic doReset(input logic pS, input logic leg, input logic asel, input logic glitch);
    @(negedge clkSys);
    resetn = 1'b0;
    pullSda = pS;
    legacySelIn = leg;
    addrSelIn = asel;
    repeat (20) @(negedge clkSys);
    resetn = 1'b1;
    repeat (20) @(negedge clkSys);
    if (glitch) begin
      pullSda = 1'b0;
      repeat (3) @(negedge clkSys);
      pullSda = 1'b1;
    end
    repeat (60) @(negedge clkSys);
    #400;
  endtask
  // Block write; n data bytes from d, low byte first; gap after STOP lets commit cross
  task automatic wr(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] cnt,
                    input int n, input logic [15:0] d, output logic ackA);
    logic k;
    host.start();
    host.writeByte({a, 1'b0}, ackA);
    if (ackA) begin
      host.writeByte(cmd, k);
      host.writeByte(cnt, k);
      for (int i = 0; i < n; i++) host.writeByte(d[8*i+:8], k);
    end
    host.stop();
    repeat (40) @(negedge clkSys);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] cmd, output logic [7:0] cnt,
                    output logic [7:0] d0);
    logic k;
    host.start();
    host.writeByte({a, 1'b0}, k);
    host.writeByte(cmd, k);
    host.start();
    host.writeByte({a, 1'b1}, k);
    host.readByte(1'b1, cnt);
    host.readByte(1'b0, d0);
    host.stop();
    repeat (40) @(negedge clkSys);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic tDisabled();
    logic ack;
    doReset(1'b1, 1'b0, 1'b0, 1'b1);
    chk(slaveEnabled, 1'b0);
    chk({otpOnly, initProceed, waitingHost}, 3'b110);
    chk(dataPullupEn, 1'b1);
    wr(SLAVE_ADDR_LO, 8'h00, 8'h01, 1, 16'h0011, ack);
    chk(ack, 1'b0);
    chk(cfgValue, OTP);
  endtask
  task automatic tAdvanced();
    logic ack, k;
    logic [7:0] cnt, d0, aw;
    logic [127:0] exp = OTP;
    doReset(1'b1, 1'b0, 1'b0, 1'b0);
    chk({slaveEnabled, legacyMode}, 2'b10);
    chk({waitingHost, initProceed}, 2'b10);
    chk(cfgValue, OTP);
    wr(SLAVE_ADDR_HI, 8'h08, 8'h01, 1, 16'h0011, ack);
    chk(ack, 1'b0);
    wr(SLAVE_ADDR_LO, 8'h08, 8'h02, 2, 16'h5aa5, ack);
    exp[79:64] = 16'h5aa5;
    chk({ack, cfgValue}, {1'b1, exp});
    wr(SLAVE_ADDR_LO, 8'h00, 8'h02, 1, 16'h0099, ack);
    chk(cfgValue, exp);
    // Unfinished write cut by a bus reset must vanish, and the next one must land
    host.start();
    host.writeByte({SLAVE_ADDR_LO, 1'b0}, k);
    host.writeByte(8'h00, k);
    host.writeByte(8'h01, k);
    host.writeByte(8'h99, k);
    host.busReset();
    repeat (40) @(negedge clkSys);
    chk(cfgValue, exp);
    wr(SLAVE_ADDR_LO, 8'h01, 8'h01, 1, 16'h0033, ack);
    exp[15:8] = 8'h33;
    chk(cfgValue, exp);
    rd(SLAVE_ADDR_LO, 8'h08, cnt, d0);
    chk({cnt, d0}, 16'h08a5);
    // Clock held low while the slave drives ACK: it must let go past the limit
    aw = {SLAVE_ADDR_LO, 1'b0};
    host.start();
    for (int i = 7; i >= 0; i--) begin
      host.sdaOeN = aw[i];
      host.pulse(k);
    end
    host.sdaOeN = 1'b1;
    #1000;
    chk(dOeN, 1'b0);
    #14000;
    chk({dOeN, cOeN}, 2'b11);
    host.stop();
    repeat (40) @(negedge clkSys);
    wr(SLAVE_ADDR_LO, 8'h02, 8'h01, 1, 16'h0044, ack);
    exp[23:16] = 8'h44;
    chk(cfgValue, exp);
    chk(waitingHost, 1'b1);
    wr(SLAVE_ADDR_LO, 8'h07, 8'h01, 1, 16'h0055, ack);
    exp[63:56] = 8'h55;
    chk({initProceed, waitingHost, cfgValue}, {2'b10, exp});
  endtask
  task automatic tLegacy();
    logic ack;
    logic [7:0] cnt, d0;
    doReset(1'b1, 1'b1, 1'b1, 1'b0);
    chk({slaveEnabled, legacyMode}, 2'b11);
    chk(cfgValue, OTP);
    wr(SLAVE_ADDR_LO, 8'h00, 8'h01, 1, 16'h0011, ack);
    chk(ack, 1'b0);
    wr(SLAVE_ADDR_HI, 8'h08, 8'h01, 1, 16'h00aa, ack);
    chk({ack, cfgValue}, {1'b1, OTP});
    rd(SLAVE_ADDR_HI, 8'h00, cnt, d0);
    chk({cnt, d0}, 16'h0888);
  endtask
  // Watchdog at 0.9 ms, over twice the expected run of about 0.4 ms, inside the cycle budget
  initial begin
    #900000;
    miscompares++;
    summarize();
  end
  initial begin
    tDisabled();
    tAdvanced();
    tLegacy();
    summarize();
  end
endmodule
`default_nettype wire
